// ---- common/uart_regs_consts.svh ----
// constants for the serial port register block
`ifndef UART_REGS_CONSTS_SVH
`define UART_REGS_CONSTS_SVH
// register indexes, byte address is four times the index
`define IDX_DATA 4'h0
`define IDX_IER 4'h1
`define IDX_IIR 4'h2
`define IDX_LCR 4'h3
`define IDX_MCR 4'h4
`define IDX_LSR 4'h5
`define IDX_MSR 4'h6
`define IDX_SCR 4'h7
`define IDX_EVT_STS 4'h8
`define IDX_EVT_CLR 4'h9
`define IDX_EVT_EN 4'hA
// line control fields and the modem control loopback bit
`define LCR_DLAB 7
`define LCR_SILENCE 6
`define LCR_FIXPAR 5
`define LCR_EVEN 4
`define LCR_PAREN 3
`define LCR_STOP2 2
`define LCR_LEN_HI 1
`define LCR_LEN_LO 0
`define MCR_LOOP 4
// reset values
`define LCR_RST 8'h03
`define DIV_RST 16'h0001
// timing in 16x ticks
`define TICK_LAST 5'h0F
`define TICK_MID 5'h07
`define STOP_ONE 5'h0F
`define STOP_HALF 5'h17
`define STOP_TWO 5'h1F
// axi responses
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// ---- common/uart_regs_pkg.sv ----
// types for the serial port register block
package uart_regs_pkg;
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_PAR = 3'b011,
    SER_STOP = 3'b100
  } ser_state_t;
  typedef logic [7:0] byte_t;
endpackage : uart_regs_pkg

// ---- rtl/uart_regs.sv ----
// serial port with axi4-lite register map and character format control
`timescale 1ns/100ps
`include "uart_regs_consts.svh"

// Operation
// - With the divisor access bit set, offsets 0 and 1 reach the divisor low and high bytes.
// - With it clear, offset 0 reads receive and takes transmit data; offset 1 is enables.
// - The silence bit drives the infrared output low while the transmitter runs on.
// - Parity enable plus fixed parity sends and checks 0 if even select is 1, else 1.
// - With parity on, even select gives an even count of ones, clear gives odd.
// - The parity bit sits between the last data bit and the stop bit both ways.
// - Stop select 0 gives one stop bit, 1 gives one and a half for 5 bits, else two.
// - The length field codes 0 to 3 select 5 to 8 data bits.
// - Data bit 0 goes first on the line and the first bit received lands in bit 0.
// - Without fifo mode the timeout and fifo bits of identification and fifo error read 0.
// - A character is start, data, optional parity, then stop bits.
// - The baud generator takes divisors 1 to 65535 and makes a 16x tick.
module uart_regs #(
  parameter int ADDR_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_rx_line,
  output logic serial_tx_line,
  output logic infrared_tx_path,
  output logic irq
);
  // ****************************************
  // declarations
  // ****************************************
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, irq_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic [7:0] lcr_ff, dll_ff, dlh_ff, scr_ff, thr_ff, tsr_ff, rbr_ff, rx_sh_ff;
  logic [3:0] ier_ff;
  logic [4:0] mcr_ff;
  logic [2:0] evt_sts_ff, evt_en_ff;
  logic [15:0] baud_cnt_ff;
  logic thr_full_ff, dr_ff, oer_ff, pber_ff, nser_ff, sbd_ff, rx_zero_ff;
  logic rx_meta_ff, rx_sync_ff, tx_out_ff, ir_out_ff, tx_par_ff;
  logic [4:0] tx_tick_ff, rx_tick_ff;
  logic [2:0] tx_bit_ff, rx_bit_ff;
  uart_regs_pkg::ser_state_t tx_state_ff, rx_state_ff;
  logic tick, tx_level, rx_in, wr_go, rd_go, tx_load, rx_done, rx_perr;
  logic [3:0] wr_idx, rd_idx;
  logic [2:0] len_last;
  logic [4:0] stop_last;
  logic [7:0] rd_byte, iir_val, lsr_val, msr_val;
  logic rd_ok;

  // ****************************************
  // helpers
  // ****************************************
  // register index of a byte address
  function automatic logic [3:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[5:2];
  endfunction : idx_of

  // keep only the selected number of data bits
  function automatic logic [7:0] len_mask(input logic [7:0] d, input logic [1:0] code);
    len_mask = d & (8'hFF >> (2'h3 - code));
  endfunction : len_mask

  // parity bit for a character under the line control setting
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] lcr);
    if (lcr[`LCR_FIXPAR]) begin
      par_of = !lcr[`LCR_EVEN];
    end else begin
      par_of = ^len_mask(d, lcr[1:0]) ^ !lcr[`LCR_EVEN];
    end
  endfunction : par_of

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_idx = idx_of(awaddr_ff);
  assign rd_go = arvalid && arready_ff;
  assign rd_idx = idx_of(araddr);

  // write address and data are taken in either order, answered once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OK;
      awaddr_ff <= '0;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready_ff) begin
        awaddr_ff <= awaddr;
        awready_ff <= 1'b0;
      end
      if (wvalid && wready_ff) begin
        wbyte_ff <= wdata[7:0];
        wlane_ff <= wstrb[0];
        wready_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_idx > `IDX_EVT_EN) ? `RESP_ERR : `RESP_OK;
      end
      if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // read mux over the register map
  always_comb begin
    iir_val = 8'h01;
    if (oer_ff || pber_ff || nser_ff || sbd_ff) begin
      iir_val = ier_ff[2] ? 8'h06 : 8'h01;
    end
    if (iir_val[0] && dr_ff && ier_ff[0]) begin
      iir_val = 8'h04;
    end
    if (iir_val[0] && !thr_full_ff && ier_ff[1]) begin
      iir_val = 8'h02;
    end
    lsr_val = {1'b0, !thr_full_ff && tx_state_ff == uart_regs_pkg::SER_IDLE, !thr_full_ff,
               sbd_ff, nser_ff, pber_ff, oer_ff, dr_ff};
    msr_val = mcr_ff[`MCR_LOOP] ? {mcr_ff[3], mcr_ff[2], mcr_ff[0], mcr_ff[1], 4'h0} : 8'h00;
    rd_ok = 1'b1;
    unique case (rd_idx)
      `IDX_DATA: rd_byte = lcr_ff[`LCR_DLAB] ? dll_ff : rbr_ff;
      `IDX_IER: rd_byte = lcr_ff[`LCR_DLAB] ? dlh_ff : {4'h0, ier_ff};
      `IDX_IIR: rd_byte = iir_val;
      `IDX_LCR: rd_byte = lcr_ff;
      `IDX_MCR: rd_byte = {3'h0, mcr_ff};
      `IDX_LSR: rd_byte = lsr_val;
      `IDX_MSR: rd_byte = msr_val;
      `IDX_SCR: rd_byte = scr_ff;
      `IDX_EVT_STS: rd_byte = {5'h00, evt_sts_ff};
      `IDX_EVT_EN: rd_byte = {5'h00, evt_en_ff};
      default: begin
        rd_byte = 8'h00;
        rd_ok = (rd_idx == `IDX_EVT_CLR);
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RESP_OK;
    end else if (ce) begin
      if (rd_go) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h00_0000, rd_byte};
        rresp_ff <= rd_ok ? `RESP_OK : `RESP_ERR;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // software writes to control, divisor, enable and scratch bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcr_ff <= `LCR_RST;
      {dlh_ff, dll_ff} <= `DIV_RST;
      ier_ff <= 4'h0;
      mcr_ff <= 5'h00;
      scr_ff <= 8'h00;
      evt_en_ff <= 3'h0;
    end else if (ce && wr_go && wlane_ff) begin
      unique case (wr_idx)
        `IDX_DATA: if (lcr_ff[`LCR_DLAB]) dll_ff <= wbyte_ff;
        `IDX_IER: begin
          if (lcr_ff[`LCR_DLAB]) begin
            dlh_ff <= wbyte_ff;
          end else begin
            ier_ff <= wbyte_ff[3:0];
          end
        end
        `IDX_LCR: lcr_ff <= wbyte_ff;
        `IDX_MCR: mcr_ff <= wbyte_ff[4:0];
        `IDX_SCR: scr_ff <= wbyte_ff;
        `IDX_EVT_EN: evt_en_ff <= wbyte_ff[2:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // baud generator
  // ****************************************
  assign tick = (baud_cnt_ff == 16'h0000);

  // counts the divisor down to one 16x tick; zero behaves as one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_cnt_ff <= 16'h0000;
    end else if (ce) begin
      if (tick) begin
        baud_cnt_ff <= ({dlh_ff, dll_ff} == 16'h0000) ? 16'h0000
                                                       : {dlh_ff, dll_ff} - 16'h0001;
      end else begin
        baud_cnt_ff <= baud_cnt_ff - 16'h0001;
      end
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  assign len_last = {1'b1, lcr_ff[1:0]};
  assign tx_load = tick && thr_full_ff && tx_state_ff == uart_regs_pkg::SER_IDLE;

  // stop length in ticks
  always_comb begin
    if (!lcr_ff[`LCR_STOP2]) begin
      stop_last = `STOP_ONE;
    end else if (lcr_ff[1:0] == 2'h0) begin
      stop_last = `STOP_HALF;
    end else begin
      stop_last = `STOP_TWO;
    end
  end

  // line level for the current transmit state
  always_comb begin
    unique case (tx_state_ff)
      uart_regs_pkg::SER_START: tx_level = 1'b0;
      uart_regs_pkg::SER_DATA: tx_level = tsr_ff[0];
      uart_regs_pkg::SER_PAR: tx_level = tx_par_ff;
      default: tx_level = 1'b1;
    endcase
  end

  // holding byte fills on a data write and empties into the shifter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_ff <= 8'h00;
      thr_full_ff <= 1'b0;
    end else if (ce) begin
      if (wr_go && wlane_ff && wr_idx == `IDX_DATA && !lcr_ff[`LCR_DLAB]) begin
        thr_ff <= wbyte_ff;
        thr_full_ff <= 1'b1;
      end else if (tx_load) begin
        thr_full_ff <= 1'b0;
      end
    end
  end

  // character sequencer, one state per field of the frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_ff <= uart_regs_pkg::SER_IDLE;
      tsr_ff <= 8'h00;
      tx_tick_ff <= 5'h00;
      tx_bit_ff <= 3'h0;
      tx_par_ff <= 1'b0;
    end else if (ce && tick) begin
      tx_tick_ff <= tx_tick_ff + 5'h01;
      unique case (tx_state_ff)
        uart_regs_pkg::SER_IDLE: begin
          tx_tick_ff <= 5'h00;
          if (thr_full_ff) begin
            tsr_ff <= len_mask(thr_ff, lcr_ff[1:0]);
            // parity taken from the whole character, the shifter loses bits as it goes
            tx_par_ff <= par_of(thr_ff, lcr_ff);
            tx_state_ff <= uart_regs_pkg::SER_START;
          end
        end
        uart_regs_pkg::SER_START: begin
          if (tx_tick_ff == `TICK_LAST) begin
            tx_tick_ff <= 5'h00;
            tx_bit_ff <= 3'h0;
            tx_state_ff <= uart_regs_pkg::SER_DATA;
          end
        end
        uart_regs_pkg::SER_DATA: begin
          if (tx_tick_ff == `TICK_LAST) begin
            tx_tick_ff <= 5'h00;
            tx_bit_ff <= tx_bit_ff + 3'h1;
            if (tx_bit_ff == len_last) begin
              tx_state_ff <= lcr_ff[`LCR_PAREN] ? uart_regs_pkg::SER_PAR
                                                : uart_regs_pkg::SER_STOP;
            end else begin
              tsr_ff <= {1'b0, tsr_ff[7:1]};
            end
          end
        end
        uart_regs_pkg::SER_PAR: begin
          if (tx_tick_ff == `TICK_LAST) begin
            tx_tick_ff <= 5'h00;
            tx_state_ff <= uart_regs_pkg::SER_STOP;
          end
        end
        uart_regs_pkg::SER_STOP: begin
          if (tx_tick_ff == stop_last) begin
            tx_tick_ff <= 5'h00;
            tx_state_ff <= uart_regs_pkg::SER_IDLE;
          end
        end
        default: tx_state_ff <= uart_regs_pkg::SER_IDLE;
      endcase
    end
  end

  // outputs: loopback holds the line idle, silence forces the infrared path low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_ff <= 1'b1;
      ir_out_ff <= 1'b1;
    end else if (ce) begin
      tx_out_ff <= mcr_ff[`MCR_LOOP] | tx_level;
      ir_out_ff <= !lcr_ff[`LCR_SILENCE] && tx_level;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  // two-stage synchroniser on the receive pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else if (ce) begin
      rx_meta_ff <= serial_rx_line;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  assign rx_in = mcr_ff[`MCR_LOOP] ? tx_level : rx_sync_ff;
  assign rx_perr = rx_in != par_of(rx_sh_ff, lcr_ff);
  assign rx_done = tick && rx_state_ff == uart_regs_pkg::SER_STOP && rx_tick_ff == `TICK_LAST;

  // samples each field at mid-bit and assembles the character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_ff <= uart_regs_pkg::SER_IDLE;
      rx_sh_ff <= 8'h00;
      rx_tick_ff <= 5'h00;
      rx_bit_ff <= 3'h0;
      rx_zero_ff <= 1'b0;
    end else if (ce && tick) begin
      rx_tick_ff <= rx_tick_ff + 5'h01;
      unique case (rx_state_ff)
        uart_regs_pkg::SER_IDLE: begin
          rx_tick_ff <= 5'h00;
          if (!rx_in) rx_state_ff <= uart_regs_pkg::SER_START;
        end
        uart_regs_pkg::SER_START: begin
          if (rx_tick_ff == `TICK_MID) begin
            rx_tick_ff <= 5'h00;
            rx_bit_ff <= 3'h0;
            rx_sh_ff <= 8'h00;
            rx_zero_ff <= 1'b1;
            rx_state_ff <= rx_in ? uart_regs_pkg::SER_IDLE : uart_regs_pkg::SER_DATA;
          end
        end
        uart_regs_pkg::SER_DATA: begin
          if (rx_tick_ff == `TICK_LAST) begin
            rx_tick_ff <= 5'h00;
            rx_sh_ff[rx_bit_ff] <= rx_in;
            rx_zero_ff <= rx_zero_ff && !rx_in;
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == len_last) begin
              rx_state_ff <= lcr_ff[`LCR_PAREN] ? uart_regs_pkg::SER_PAR
                                                : uart_regs_pkg::SER_STOP;
            end
          end
        end
        uart_regs_pkg::SER_PAR: begin
          if (rx_tick_ff == `TICK_LAST) begin
            rx_tick_ff <= 5'h00;
            rx_zero_ff <= rx_zero_ff && !rx_in;
            rx_state_ff <= uart_regs_pkg::SER_STOP;
          end
        end
        uart_regs_pkg::SER_STOP: begin
          if (rx_tick_ff == `TICK_LAST) begin
            rx_tick_ff <= 5'h00;
            rx_state_ff <= uart_regs_pkg::SER_IDLE;
          end
        end
        default: rx_state_ff <= uart_regs_pkg::SER_IDLE;
      endcase
    end
  end

  // line status flags: a new event wins over a clearing read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rbr_ff <= 8'h00;
      dr_ff <= 1'b0;
      {sbd_ff, nser_ff, pber_ff, oer_ff} <= 4'h0;
    end else if (ce) begin
      if (rd_go && rd_idx == `IDX_DATA && !lcr_ff[`LCR_DLAB]) dr_ff <= 1'b0;
      if (rd_go && rd_idx == `IDX_LSR) {sbd_ff, nser_ff, pber_ff, oer_ff} <= 4'h0;
      if (tick && rx_state_ff == uart_regs_pkg::SER_PAR && rx_tick_ff == `TICK_LAST
          && rx_perr) begin
        pber_ff <= 1'b1;
      end
      if (rx_done) begin
        rbr_ff <= rx_sh_ff;
        dr_ff <= 1'b1;
        if (dr_ff) oer_ff <= 1'b1;
        if (!rx_in) nser_ff <= 1'b1;
        if (!rx_in && rx_zero_ff) sbd_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // event interrupt: rx done, tx holding empty, framing or overrun error
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_sts_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      evt_sts_ff <= (evt_sts_ff & ~((wr_go && wlane_ff && wr_idx == `IDX_EVT_CLR)
                                    ? wbyte_ff[2:0] : 3'h0))
                    | {rx_done && (!rx_in || dr_ff), tx_load, rx_done};
      irq_ff <= |(evt_sts_ff & evt_en_ff);
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign serial_tx_line = tx_out_ff;
  assign infrared_tx_path = ir_out_ff;
  assign irq = irq_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence rd_at(logic [3:0] i);
    ce && rd_go && rd_idx == i;
  endsequence

  chk_divisor_low_rd: assert property (
      rd_at(`IDX_DATA) ##0 lcr_ff[`LCR_DLAB] |=> rdata[7:0] == $past(dll_ff))
    else $error("divisor low not read");
  chk_rx_data_rd: assert property (
      rd_at(`IDX_DATA) ##0 !lcr_ff[`LCR_DLAB] |=> rdata[7:0] == $past(rbr_ff))
    else $error("receive byte not read");
  chk_enable_upper: assert property (
      rd_at(`IDX_IER) ##0 !lcr_ff[`LCR_DLAB] |=> rdata[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  chk_fifo_bits_zero: assert property (
      rd_at(`IDX_IIR) |=> rdata[7:6] == 2'h0 && !rdata[3])
    else $error("fifo bits set");
  chk_silence_out: assert property (
      ce && lcr_ff[`LCR_SILENCE] |=> !infrared_tx_path)
    else $error("silence not forced");
  chk_parity_bit: assert property (
      ce && tx_state_ff == uart_regs_pkg::SER_PAR && !mcr_ff[`MCR_LOOP]
      |=> serial_tx_line == $past(tx_par_ff))
    else $error("parity bit wrong");
  chk_lsb_first: assert property (
      ce && tx_state_ff == uart_regs_pkg::SER_DATA && !mcr_ff[`MCR_LOOP]
      |=> serial_tx_line == $past(tsr_ff[0]))
    else $error("data bit order wrong");
  chk_stop_length: assert property (
      ce && tick && tx_state_ff == uart_regs_pkg::SER_STOP && tx_tick_ff > stop_last |-> 1'b0)
    else $error("stop longer than selected");
  chk_baud_reload: assert property (
      ce && tick && {dlh_ff, dll_ff} > 16'h0001 |=> !tick)
    else $error("tick too early");
  chk_start_first: assert property (
      ce && tick && tx_load |=> tx_state_ff == uart_regs_pkg::SER_START)
    else $error("frame not opened by start");
endmodule : uart_regs

// ---- bench/serial_peer.sv ----
// serial peer model facing the block's transmit and receive lines
`timescale 1ns/100ps

// ************************************************************
// serial peer
// ************************************************************
module serial_peer (
  input wire logic aclk,
  input wire logic line_in,
  input wire logic [7:0] cpb,
  input wire logic [7:0] nsamp,
  output logic line_out,
  output logic [15:0] cap,
  output int nframes
);
  // catch a frame at mid-bit: start, data lsb first, parity, stop bits
  initial begin
    line_out = 1'b1;
    cap = 16'h0000;
    nframes = 0;
    forever begin
      @(negedge line_in);
      repeat (cpb / 2) @(posedge aclk);
      cap = 16'h0000;
      for (int i = 0; i < nsamp; i++) begin
        cap[i] = line_in;
        if (i < nsamp - 1) repeat (cpb) @(posedge aclk);
      end
      nframes++;
    end
  end

  // send one frame, bit 0 of v first, then return the line to idle high
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= v[i];
      repeat (cpb) @(posedge aclk);
    end
    line_out <= 1'b1;
  endtask : send
endmodule : serial_peer

// ---- bench/tb_uart_regs.sv ----
// self-checking testbench for the serial port register block
`timescale 1ns/100ps
`include "uart_regs_consts.svh"

// ************************************************************
// bench top
// ************************************************************
module tb_uart_regs;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, ir_high;
  logic serial_rx_line, serial_tx_line, infrared_tx_path;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp_v;
  logic [7:0] cpb, nsamp;
  logic [15:0] cap;
  int nframes, n_errors, checked;
  logic [7:0] tl [8] = '{8'h00, 8'h01, 8'h0A, 8'h1B, 8'h2B, 8'h3B, 8'h07, 8'h04};
  logic [7:0] td [8] = '{8'h16, 8'h2B, 8'h55, 8'hC3, 8'h81, 8'h81, 8'hE4, 8'h0D};

  uart_regs uut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .serial_rx_line, .serial_tx_line, .infrared_tx_path, .irq);
  serial_peer peer (.aclk, .line_in(serial_tx_line), .cpb, .nsamp,
    .line_out(serial_rx_line), .cap, .nframes);

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // note any high level on the infrared output
  always @(posedge aclk) if (infrared_tx_path === 1'b1) ir_high <= 1'b1;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // axi4-lite write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp_v = bresp;
    bready <= 1'b0;
  endtask : wr

  // axi4-lite read, data and response taken at the rvalid edge
  task automatic rd(input logic [3:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    resp_v = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [3:0] idx, input logic [7:0] exp, input string nm);
    rd(idx);
    chk(nm, rd_v, {24'h000000, exp});
  endtask : rc

  // expected line bits of one character; unused upper positions stay at stop level
  function automatic logic [15:0] frame(input logic [7:0] lcr, input logic [7:0] d);
    int n;
    logic p;
    logic [15:0] v;
    n = 5 + lcr[1:0];
    v = 16'hFFFF;
    v[0] = 1'b0;
    for (int i = 0; i < n; i++) v[i + 1] = d[i];
    p = ^(d & ((8'h01 << n) - 8'h01)) ^ ~lcr[4];
    if (lcr[5]) p = ~lcr[4];
    if (lcr[3]) v[n + 1] = p;
    return v;
  endfunction : frame

  // send one character and compare what the peer caught
  task automatic tx(input logic [7:0] lcr, input logic [7:0] d);
    int f0;
    int ns;
    logic [15:0] m;
    ns = 7 + lcr[1:0] + lcr[3] + (lcr[2] && lcr[1:0] != 2'h0);
    nsamp = ns[7:0];
    wr(`IDX_LCR, lcr);
    f0 = nframes;
    wr(`IDX_DATA, d);
    for (int t = 0; t < 6000 && nframes == f0; t++) @(posedge aclk);
    // let the last stop bit run out before line control is touched again
    repeat (cpb) @(posedge aclk);
    m = frame(lcr, d) & ((16'h1 << ns) - 16'h1);
    chk("tx frame", {16'h0000, cap}, {16'h0000, m});
  endtask : tx

  // peer sends a frame, then status and data are read back
  task automatic rx(input logic [7:0] lcr, input logic [15:0] v, input int n,
    input logic [7:0] ed, input logic [7:0] es);
    wr(`IDX_LCR, lcr);
    @(posedge aclk);
    peer.send(v, n);
    repeat (cpb * 2) @(posedge aclk);
    rc(`IDX_LSR, es, "rx status");
    rc(`IDX_DATA, ed, "rx data");
  endtask : rx

  // watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    close_out();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ir_high} = 7'h00;
    {awaddr, araddr, wdata} = 44'h0;
    ce = 1'b1;
    wstrb = 4'hF;
    cpb = 8'h10;
    nsamp = 8'h0A;
    n_errors = 0;
    checked = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`IDX_LCR, 8'h03, "line ctl reset");
    rc(`IDX_IIR, 8'h01, "ident");
    rc(`IDX_LSR, 8'h60, "line status");
    wr(`IDX_IIR, 8'hC1);
    rc(`IDX_IIR, 8'h01, "ident fifo bits");
    wr(`IDX_IER, 8'hFF);
    rc(`IDX_IER, 8'h0F, "enables");
    wr(`IDX_SCR, 8'hA5);
    chk("bresp ok", resp_v, `RESP_OK);
    rc(`IDX_SCR, 8'hA5, "scratch");
    chk("rresp ok", resp_v, `RESP_OK);
    wr(`IDX_MCR, 8'h0B);
    rc(`IDX_MCR, 8'h0B, "modem ctl");
    wr(`IDX_LCR, 8'h83);
    rc(`IDX_DATA, 8'h01, "div low reset");
    rc(`IDX_IER, 8'h00, "div high reset");
    wr(`IDX_DATA, 8'h34);
    wr(`IDX_IER, 8'h12);
    rc(`IDX_DATA, 8'h34, "div low");
    rc(`IDX_IER, 8'h12, "div high");
    wr(`IDX_LCR, 8'h03);
    rc(`IDX_IER, 8'h0F, "enables kept");
    wr(`IDX_IER, 8'h00);
    wr(`IDX_LCR, 8'h83);
    wr(`IDX_DATA, 8'h02);
    wr(`IDX_IER, 8'h00);
    cpb = 8'h20;
    tx(8'h03, 8'h5A);
    wr(`IDX_LCR, 8'h83);
    wr(`IDX_DATA, 8'h01);
    cpb = 8'h10;
    for (int i = 0; i < 8; i++) tx(tl[i], td[i]);
    wr(`IDX_LCR, 8'h43);
    repeat (2) @(posedge aclk);
    ir_high = 1'b0;
    tx(8'h43, 8'h96);
    chk("ir silent", ir_high, 32'h0);
    wr(`IDX_LCR, 8'h03);
    repeat (3) @(posedge aclk);
    chk("ir idle", infrared_tx_path, 32'h1);
    wr(`IDX_EVT_CLR, 8'h07);
    rc(`IDX_EVT_STS, 8'h00, "events cleared");
    rx(8'h03, frame(8'h03, 8'hA5), 10, 8'hA5, 8'h61);
    rc(`IDX_EVT_STS, 8'h01, "rx event");
    chk("irq masked", irq, 32'h0);
    wr(`IDX_EVT_EN, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq raised", irq, 32'h1);
    wr(`IDX_EVT_EN, 8'h02);
    repeat (2) @(posedge aclk);
    chk("irq other mask", irq, 32'h0);
    wr(`IDX_EVT_EN, 8'h01);
    wr(`IDX_EVT_CLR, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 32'h0);
    rc(`IDX_EVT_STS, 8'h00, "event cleared");
    rx(8'h1B, frame(8'h1B, 8'h01) ^ 16'h0200, 11, 8'h01, 8'h65);
    rx(8'h2B, frame(8'h2B, 8'h3C), 11, 8'h3C, 8'h61);
    rx(8'h00, frame(8'h00, 8'h15), 7, 8'h15, 8'h61);
    rx(8'h03, frame(8'h03, 8'hA5) & 16'hFDFF, 10, 8'hA5, 8'h69);
    rc(`IDX_EVT_STS, 8'h05, "error event");
    // internal loopback: line held high, character comes back through the receiver
    wr(`IDX_MCR, 8'h1B);
    rc(`IDX_MSR, 8'hB0, "loop status");
    wr(`IDX_DATA, 8'h3C);
    repeat (200) @(posedge aclk);
    rc(`IDX_DATA, 8'h3C, "loop data");
    wr(`IDX_MCR, 8'h0B);
    rd(4'hC);
    chk("unmapped data", rd_v, 32'h0);
    chk("unmapped rresp", resp_v, `RESP_ERR);
    wr(4'hF, 8'h00);
    chk("unmapped bresp", resp_v, `RESP_ERR);
    close_out();
  end
endmodule : tb_uart_regs
